// [verilog/mpm_param_map.sv]
// Register map behind a serial Modbus RTU slave port of a drive.
// Assumes a frame engine on the same clock hands over parsed requests,
// and an external nonvolatile store that reports done or failure.
//
// What this block does
// - Baud codes 0..5, code 2 after reset
// - Format codes 0..3 select parity and stops
// - Persist selector 1 commits writes to nonvolatile
// - Word order code picks high or low first
// - 32-bit monitor spans two consecutive addresses
// - Parameters 0x0001..0x0D08 read and write
// - Monitors 0x1E01..0x2010 are read only
// - Address is group high, index low
// - Monitors use same scheme from 0x1E01
// - Signed values carried as two's complement
// - Unsigned values carried unchanged
// - Scaled values carried as integer step counts
// - Memory failure raises fault that only reset clears
// - Accept function codes 0x03, 0x06, 0x10
// - Errors echo function with bit 7 set
module mpm_param_map (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_count,
  input wire logic [31:0] req_data,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [7:0] rsp_func,
  output logic [7:0] rsp_code,
  output logic [31:0] rsp_data,
  input wire logic [15:0] servo_state,
  input wire logic [31:0] turn_position,
  output logic nvm_req,
  output logic [15:0] nvm_addr,
  output logic [31:0] nvm_data,
  output logic nvm_wide,
  input wire logic nvm_done,
  input wire logic nvm_fail,
  output logic drive_fault,
  output logic [15:0] control_mode,
  output logic [15:0] node_address,
  output logic [2:0] baud_code,
  output logic [15:0] bit_cycles,
  output logic parity_en,
  output logic parity_odd,
  output logic stop_two,
  output logic word_order,
  output logic persist_en
);
  import mpm_pkg::*;

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  mpm_state_s state_q; // Registered state
  mpm_state_s state_d; // Next state

  // Parameter range check
  function automatic logic in_param(input logic [15:0] a);
    in_param = (a >= MPM_PARAM_LO) && (a <= MPM_PARAM_HI);
  endfunction

  // Monitor range check; same group/index layout, offset base
  function automatic logic in_mon(input logic [15:0] a);
    in_mon = (a >= MPM_MON_LO) && (a <= MPM_MON_HI);
  endfunction

  // Next address of a pair
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = 16'(a + 16'h0001);
  endfunction

  // Clock cycles per serial bit for a baud code
  function automatic logic [15:0] cycles_for(input logic [2:0] code);
    case (code)
      3'h0: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_0);
      3'h1: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_1);
      3'h2: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_2);
      3'h3: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_3);
      3'h4: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_4);
      default: cycles_for = 16'(MPM_CLK_HZ / MPM_BPS_5);
    endcase
  endfunction

  // Range limit of a value written to a selector
  function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v);
    case (a)
      MPM_ADDR_BAUD: value_ok = (v <= MPM_MAX_BAUD);
      MPM_ADDR_FMT: value_ok = (v <= MPM_MAX_FMT);
      MPM_ADDR_PERSIST: value_ok = (v <= MPM_MAX_BIT);
      MPM_ADDR_WORDER: value_ok = (v <= MPM_MAX_BIT);
      default: value_ok = 1'b1;
    endcase
  endfunction

  // One 16-bit register read; words pass as raw bits, sign and scale kept
  function automatic logic [15:0] read16(input mpm_state_s s, input logic [15:0] a);
    case (a)
      MPM_ADDR_CTRL_MODE: read16 = s.ctrl_mode;
      MPM_ADDR_NODE: read16 = s.node_addr;
      MPM_ADDR_BAUD: read16 = {13'h0000, s.baud};
      MPM_ADDR_FMT: read16 = {14'h0000, s.fmt};
      MPM_ADDR_PERSIST: read16 = {15'h0000, s.persist};
      MPM_ADDR_WORDER: read16 = {15'h0000, s.worder};
      MPM_ADDR_STATE: read16 = servo_state;
      // Lower address of the pair: high half unless low-first order
      MPM_ADDR_POS: read16 = s.worder ? turn_position[15:0] : turn_position[31:16];
      16'h1e3e: read16 = s.worder ? turn_position[31:16] : turn_position[15:0];
      default: read16 = 16'h0000;
    endcase
  endfunction

  // One 16-bit register write, raw bits stored as carried
  function automatic mpm_state_s write16(input mpm_state_s s, input logic [15:0] a,
                                         input logic [15:0] v);
    mpm_state_s r;
    r = s;
    case (a)
      MPM_ADDR_CTRL_MODE: r.ctrl_mode = v;
      MPM_ADDR_NODE: r.node_addr = v;
      MPM_ADDR_BAUD: r.baud = v[2:0];
      MPM_ADDR_FMT: r.fmt = v[1:0];
      MPM_ADDR_PERSIST: r.persist = v[0];
      MPM_ADDR_WORDER: r.worder = v[0];
      default: r = s; // Unbacked parameters accept and drop
    endcase
    write16 = r;
  endfunction

  // ------------------------------------------------------------------
  // Request handling
  // ------------------------------------------------------------------
  logic [15:0] addr_b; // Second address of a pair
  logic [15:0] word_lo_addr; // Word stored at the lower address
  logic [15:0] word_hi_addr; // Word stored at the next address
  logic take; // Request accepted this cycle

  assign addr_b = next_addr(req_addr);
  // Word order picks which half lands at the lower address
  assign word_lo_addr = state_q.worder ? req_data[15:0] : req_data[31:16];
  assign word_hi_addr = state_q.worder ? req_data[31:16] : req_data[15:0];
  // A pending commit holds off new requests so none is lost
  assign req_ready = ~state_q.nvm_busy;
  assign take = req_valid & req_ready;

  // Next-state logic for the whole block
  always_comb begin
    state_d = state_q;
    state_d.rsp_valid = 1'b0;
    state_d.nvm_req = 1'b0;
    // Commit completion frees the port
    if (nvm_done) begin
      state_d.nvm_busy = 1'b0;
    end
    // Memory failure is sticky; only a full reset clears it
    if (nvm_fail) begin
      state_d.fault = 1'b1;
    end
    if (take) begin
      state_d.rsp_valid = 1'b1;
      state_d.rsp_err = 1'b0;
      state_d.rsp_func = req_func;
      state_d.rsp_code = 8'h00;
      state_d.rsp_data = 32'h0000_0000;
      case (req_func)
        // Read of one word or one 32-bit pair
        MPM_FC_READ: begin
          if ((req_count == 8'h00) || (req_count > 8'h02)) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DATA;
          end else if (!(in_param(req_addr) || in_mon(req_addr)) ||
                       ((req_count == 8'h02) && !(in_param(addr_b) || in_mon(addr_b)))) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_ADDR;
          end else if (req_count == 8'h02) begin
            state_d.rsp_data = {read16(state_q, req_addr), read16(state_q, addr_b)};
          end else begin
            state_d.rsp_data = {16'h0000, read16(state_q, req_addr)};
          end
        end
        // Single 16-bit write, parameters only
        MPM_FC_WRITE1: begin
          if (!in_param(req_addr)) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_ADDR;
          end else if (!value_ok(req_addr, req_data[15:0])) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DATA;
          end else if (state_q.persist && state_q.fault) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DEV;
          end else begin
            state_d = write16(state_d, req_addr, req_data[15:0]);
            state_d.rsp_data = {16'h0000, req_data[15:0]};
            // Commit only when persistence is on
            if (state_q.persist) begin
              state_d.nvm_req = 1'b1;
              state_d.nvm_busy = 1'b1;
              state_d.nvm_addr = req_addr;
              state_d.nvm_data = {16'h0000, req_data[15:0]};
              state_d.nvm_wide = 1'b0;
            end
          end
        end
        // 32-bit write over a parameter pair
        MPM_FC_WRITEN: begin
          if (req_count != 8'h02) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DATA;
          end else if (!in_param(req_addr) || !in_param(addr_b)) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_ADDR;
          end else if (!value_ok(req_addr, word_lo_addr) ||
                       !value_ok(addr_b, word_hi_addr)) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DATA;
          end else if (state_q.persist && state_q.fault) begin
            state_d.rsp_err = 1'b1;
            state_d.rsp_code = MPM_EX_DEV;
          end else begin
            state_d = write16(state_d, req_addr, word_lo_addr);
            state_d = write16(state_d, addr_b, word_hi_addr);
            state_d.rsp_data = {24'h000000, req_count};
            if (state_q.persist) begin
              state_d.nvm_req = 1'b1;
              state_d.nvm_busy = 1'b1;
              state_d.nvm_addr = req_addr;
              state_d.nvm_data = req_data;
              state_d.nvm_wide = 1'b1;
            end
          end
        end
        // Anything else is an unknown command
        default: begin
          state_d.rsp_err = 1'b1;
          state_d.rsp_code = MPM_EX_FUNC;
        end
      endcase
      // Exceptions echo the function with the marker bit set
      if (state_d.rsp_err) begin
        state_d.rsp_func = req_func | MPM_FC_ERR_BIT;
      end
    end
  end

  // State register with defined reset values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      state_q.ctrl_mode <= MPM_RST_CTRL_MODE;
      state_q.node_addr <= MPM_RST_NODE;
      state_q.baud <= MPM_RST_BAUD;
      state_q.fmt <= MPM_RST_FMT;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rsp_valid = state_q.rsp_valid;
  assign rsp_error = state_q.rsp_err;
  assign rsp_func = state_q.rsp_func;
  assign rsp_code = state_q.rsp_code;
  assign rsp_data = state_q.rsp_data;
  assign nvm_req = state_q.nvm_req;
  assign nvm_addr = state_q.nvm_addr;
  assign nvm_data = state_q.nvm_data;
  assign nvm_wide = state_q.nvm_wide;
  assign drive_fault = state_q.fault;
  assign control_mode = state_q.ctrl_mode;
  assign node_address = state_q.node_addr;
  assign baud_code = state_q.baud;
  // Bit timing follows the register straight away
  assign bit_cycles = cycles_for(state_q.baud);
  assign parity_en = (state_q.fmt == MPM_FMT_ODD) || (state_q.fmt == MPM_FMT_EVEN);
  assign parity_odd = (state_q.fmt == MPM_FMT_ODD);
  assign stop_two = (state_q.fmt == MPM_FMT_TWO_STOP);
  assign word_order = state_q.worder;
  assign persist_en = state_q.persist;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Accepted good single write
  sequence s_write_ok;
    take && (req_func == MPM_FC_WRITE1) && in_param(req_addr) &&
      value_ok(req_addr, req_data[15:0]) && !state_q.fault;
  endsequence

  // Accepted 32-bit read of the position pair
  sequence s_pos_read;
    take && (req_func == MPM_FC_READ) && (req_count == 8'h02) && (req_addr == MPM_ADDR_POS);
  endsequence

  a_answer_next: assert property (@(posedge clk) disable iff (reset)
    take |=> rsp_valid ##1 (rsp_valid == $past(take)))
    else $error("answer not given one cycle after request");

  a_baud_range: assert property (@(posedge clk) disable iff (reset)
    (baud_code <= 3'h5) && (bit_cycles == cycles_for(baud_code)))
    else $error("baud selector out of range");

  a_format_pins: assert property (@(posedge clk) disable iff (reset)
    !(parity_en && stop_two) && (parity_odd -> parity_en))
    else $error("frame format decode inconsistent");

  a_commit_gate: assert property (@(posedge clk) disable iff (reset)
    s_write_ok |=> (nvm_req == $past(persist_en)) && (nvm_addr == $past(req_addr) || !nvm_req))
    else $error("commit does not follow persistence selector");

  a_pair_order: assert property (@(posedge clk) disable iff (reset)
    s_pos_read |=> rsp_data == ($past(word_order) ?
      {$past(turn_position[15:0]), $past(turn_position[31:16])} : $past(turn_position)))
    else $error("32-bit word order wrong");

  a_ro_reject: assert property (@(posedge clk) disable iff (reset)
    take && (req_func == MPM_FC_WRITE1) && in_mon(req_addr)
      |=> rsp_error && (rsp_code == MPM_EX_ADDR) && $stable(node_address))
    else $error("write to read-only range not refused");

  a_param_store: assert property (@(posedge clk) disable iff (reset)
    s_write_ok ##0 (req_addr == MPM_ADDR_NODE)
      |=> (node_address == $past(req_data[15:0])) && rsp_valid && !rsp_error)
    else $error("parameter write not stored");

  a_fault_sticky: assert property (@(posedge clk) disable iff (reset)
    nvm_fail |=> drive_fault [*3])
    else $error("memory fault not held");

  a_error_mark: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_error |-> rsp_func[7] && (rsp_code != 8'h00))
    else $error("exception lacks marker bit");

endmodule // mpm_param_map

// [verilog/mpm_pkg.sv]
// Package for the serial parameter map: addresses, codes, reset values.
// Assumes a 25 MHz system clock and a frame engine outside that parses requests.
package mpm_pkg;

  // ------------------------------------------------------------------
  // Clock and serial rates
  // ------------------------------------------------------------------
  localparam int MPM_CLK_HZ = 25_000_000; // System clock rate
  localparam int MPM_BPS_0 = 2400; // Baud code 0
  localparam int MPM_BPS_1 = 4800; // Baud code 1
  localparam int MPM_BPS_2 = 9600; // Baud code 2
  localparam int MPM_BPS_3 = 19200; // Baud code 3
  localparam int MPM_BPS_4 = 38400; // Baud code 4
  localparam int MPM_BPS_5 = 57600; // Baud code 5

  // ------------------------------------------------------------------
  // Address ranges and register addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] MPM_PARAM_LO = 16'h0001; // First parameter
  localparam logic [15:0] MPM_PARAM_HI = 16'h0d08; // Last parameter
  localparam logic [15:0] MPM_MON_LO = 16'h1e01; // First monitor
  localparam logic [15:0] MPM_MON_HI = 16'h2010; // Last monitor
  localparam logic [15:0] MPM_ADDR_CTRL_MODE = 16'h0001; // control_mode_select
  localparam logic [15:0] MPM_ADDR_NODE = 16'h0c01; // node_address
  localparam logic [15:0] MPM_ADDR_BAUD = 16'h0c02; // baud_select
  localparam logic [15:0] MPM_ADDR_FMT = 16'h0c03; // frame_format_select
  localparam logic [15:0] MPM_ADDR_PERSIST = 16'h0c04; // persist_write_select
  localparam logic [15:0] MPM_ADDR_WORDER = 16'h0c06; // word_order_select
  localparam logic [15:0] MPM_ADDR_STATE = 16'h1e01; // servo_state_monitor
  localparam logic [15:0] MPM_ADDR_POS = 16'h1e3d; // single_turn_position_monitor

  // ------------------------------------------------------------------
  // Reset values and selector limits
  // ------------------------------------------------------------------
  localparam logic [15:0] MPM_RST_CTRL_MODE = 16'h0001; // Position control
  localparam logic [15:0] MPM_RST_NODE = 16'h0001; // Node address
  localparam logic [2:0] MPM_RST_BAUD = 3'h2; // 9600 bit/s
  localparam logic [1:0] MPM_RST_FMT = 2'h0; // 1 stop, no parity
  localparam logic [15:0] MPM_MAX_BAUD = 16'h0005; // Highest baud code
  localparam logic [15:0] MPM_MAX_FMT = 16'h0003; // Highest format code
  localparam logic [15:0] MPM_MAX_BIT = 16'h0001; // Highest flag code
  localparam logic [1:0] MPM_FMT_ODD = 2'h1; // Odd parity code
  localparam logic [1:0] MPM_FMT_EVEN = 2'h2; // Even parity code
  localparam logic [1:0] MPM_FMT_TWO_STOP = 2'h3; // Two stop bits code

  // ------------------------------------------------------------------
  // Function and exception codes
  // ------------------------------------------------------------------
  localparam logic [7:0] MPM_FC_READ = 8'h03; // Read holding registers
  localparam logic [7:0] MPM_FC_WRITE1 = 8'h06; // Write one register
  localparam logic [7:0] MPM_FC_WRITEN = 8'h10; // Write 32-bit pair
  localparam logic [7:0] MPM_FC_ERR_BIT = 8'h80; // Exception marker
  localparam logic [7:0] MPM_EX_FUNC = 8'h01; // Illegal command code
  localparam logic [7:0] MPM_EX_ADDR = 8'h02; // Illegal data address
  localparam logic [7:0] MPM_EX_DATA = 8'h03; // Illegal data
  localparam logic [7:0] MPM_EX_DEV = 8'h04; // Slave device failure

  // Whole block state, registered as one word
  typedef struct packed {
    logic [15:0] ctrl_mode; // control_mode_select
    logic [15:0] node_addr; // node_address
    logic [2:0] baud; // baud_select
    logic [1:0] fmt; // frame_format_select
    logic persist; // persist_write_select
    logic worder; // word_order_select
    logic rsp_valid; // Answer strobe
    logic rsp_err; // Answer is an exception
    logic [7:0] rsp_func; // Echoed function code
    logic [7:0] rsp_code; // Exception code
    logic [31:0] rsp_data; // Read data
    logic nvm_busy; // Commit outstanding
    logic nvm_req; // Commit strobe
    logic [15:0] nvm_addr; // Commit address
    logic [31:0] nvm_data; // Commit data
    logic nvm_wide; // Commit holds two words
    logic fault; // Nonvolatile memory fault
  } mpm_state_s;

endpackage

// [tb/mpm_nvm_model.sv]
// Behavioural nonvolatile store standing at the commit side of the map.
// Assumes one system clock; answers each commit after lat cycles.
module mpm_nvm_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic nvm_req,
  input wire logic [15:0] nvm_addr,
  input wire logic [31:0] nvm_data,
  input wire logic [31:0] lat,
  input wire logic fail_cmd,
  output logic nvm_done,
  output logic nvm_fail,
  output logic [15:0] seen_addr,
  output logic [31:0] seen_data,
  output int n_commits
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Failure line, raised only when a scenario commands it
  // --------------------------------------------------------------
  assign nvm_fail = fail_cmd;
  // Commit capture; slow answers keep the map stalled meanwhile
  initial begin
    nvm_done = 1'b0;
    n_commits = 0;
    seen_addr = 16'h0000;
    seen_data = 32'h0000_0000;
    forever begin
      @(posedge clk);
      if (nvm_req === 1'b1 && reset === 1'b0) begin
        seen_addr = nvm_addr;
        seen_data = nvm_data;
        n_commits++;
        repeat (lat) @(posedge clk);
        @(negedge clk) nvm_done = 1'b1;
        @(negedge clk) nvm_done = 1'b0;
      end
    end
  end
endmodule // mpm_nvm_model

// [tb/testbench.sv]
// Self-checking bench for the serial parameter map.
// Assumes the map is driven at falling edges by a host request task.
module testbench;
  import mpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk, reset, req_valid, req_ready, rsp_valid, rsp_error;
  logic [7:0] req_func, req_count, rsp_func, rsp_code;
  logic [15:0] req_addr, servo_state, nvm_addr, control_mode;
  logic [15:0] node_address, bit_cycles, seen_addr;
  logic [31:0] req_data, rsp_data, turn_position, nvm_data, seen_data;
  logic nvm_req, nvm_wide, nvm_done, nvm_fail, drive_fault, fail_cmd;
  logic [2:0] baud_code;
  logic parity_en, parity_odd, stop_two, word_order, persist_en;
  int n_errors = 0; // Mismatch count
  int checks_done = 0; // Comparison count
  int lat = 2; // Store answer delay
  int n_commits;
  int bps [6] = '{MPM_BPS_0, MPM_BPS_1, MPM_BPS_2, MPM_BPS_3, MPM_BPS_4, MPM_BPS_5};
  logic [2:0] fmt_exp [4] = '{3'b000, 3'b110, 3'b100, 3'b001}; // {en,odd,two}

  mpm_param_map dut_u (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_func(req_func), .req_addr(req_addr),
    .req_count(req_count), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_func(rsp_func), .rsp_code(rsp_code),
    .rsp_data(rsp_data), .servo_state(servo_state), .turn_position(turn_position),
    .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .nvm_wide(nvm_wide),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .drive_fault(drive_fault),
    .control_mode(control_mode), .node_address(node_address), .baud_code(baud_code),
    .bit_cycles(bit_cycles), .parity_en(parity_en), .parity_odd(parity_odd),
    .stop_two(stop_two), .word_order(word_order), .persist_en(persist_en));

  mpm_nvm_model nvm_u (.clk(clk), .reset(reset), .nvm_req(nvm_req),
    .nvm_addr(nvm_addr), .nvm_data(nvm_data), .lat(lat), .fail_cmd(fail_cmd),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .seen_addr(seen_addr),
    .seen_data(seen_data), .n_commits(n_commits));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  // Compare and count; four-state so unknowns never match
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One host request, held until taken; answer read one cycle later
  task automatic req(input logic [7:0] f, input logic [15:0] a,
                     input logic [7:0] c, input logic [31:0] d);
    int k;
    @(negedge clk);
    req_func = f;
    req_addr = a;
    req_count = c;
    req_data = d;
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    chk({k < 200, rsp_valid}, 2'b11);
  endtask
  // Request expected to come back as an exception
  task automatic ex(input logic [7:0] f, input logic [15:0] a,
                    input logic [7:0] d, input logic [7:0] code);
    req(f, a, 8'h01, {24'h0, d});
    chk({rsp_error, rsp_func, rsp_code}, {1'b1, f | MPM_FC_ERR_BIT, code});
  endtask
  // Verdict; the single place where the run ends
  task automatic stop_test();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk({baud_code, bit_cycles}, {3'h2, 16'd2604});
    chk({parity_en, parity_odd, stop_two}, 3'b000);
    chk({word_order, persist_en, req_ready}, 3'b001);
    $display("t_reset done");
  endtask
  // Every baud code, then one past the top which must be refused
  task automatic t_baud();
    for (int i = 0; i < 6; i++) begin
      req(MPM_FC_WRITE1, MPM_ADDR_BAUD, 8'h01, i);
      chk({baud_code, bit_cycles}, {3'(i), 16'(MPM_CLK_HZ / bps[i])});
    end
    ex(MPM_FC_WRITE1, MPM_ADDR_BAUD, 8'h06, MPM_EX_DATA);
    chk(baud_code, 3'h5);
    $display("t_baud done");
  endtask
  task automatic t_fmt();
    for (int i = 0; i < 4; i++) begin
      req(MPM_FC_WRITE1, MPM_ADDR_FMT, 8'h01, i);
      chk({parity_en, parity_odd, stop_two}, fmt_exp[i]);
    end
    ex(MPM_FC_WRITE1, MPM_ADDR_FMT, 8'h04, MPM_EX_DATA);
    $display("t_fmt done");
  endtask
  // Both word orders on the 32-bit monitor pair
  task automatic t_order();
    for (int o = 0; o < 2; o++) begin
      req(MPM_FC_WRITE1, MPM_ADDR_WORDER, 8'h01, o);
      req(MPM_FC_READ, MPM_ADDR_POS, 8'h02, 32'h0);
      chk(rsp_data, o ? 32'h5678_1234 : 32'h1234_5678);
    end
    req(MPM_FC_READ, MPM_ADDR_POS + 16'h0001, 8'h01, 32'h0);
    chk(rsp_data, 32'h0000_1234);
    req(MPM_FC_READ, MPM_ADDR_STATE, 8'h01, 32'h0);
    chk(rsp_data, 32'h0000_00a5);
    $display("t_order done");
  endtask
  // Address ranges, value encodings and command codes
  task automatic t_map();
    req(MPM_FC_WRITE1, MPM_ADDR_NODE, 8'h01, 32'h0000_ff9c);
    req(MPM_FC_READ, MPM_ADDR_NODE, 8'h01, 32'h0);
    chk({rsp_error, rsp_code}, 9'h000);
    chk(rsp_data, 32'h0000_ff9c);
    chk(node_address, 16'hff9c);
    req(MPM_FC_WRITE1, MPM_ADDR_CTRL_MODE, 8'h01, 32'h0000_8000);
    chk(control_mode, 16'h8000);
    req(MPM_FC_WRITE1, MPM_ADDR_CTRL_MODE, 8'h01, 32'd1000);
    chk(control_mode, 16'd1000);
    req(MPM_FC_READ, MPM_PARAM_HI, 8'h01, 32'h0);
    chk(rsp_error, 1'b0);
    ex(MPM_FC_WRITE1, MPM_MON_LO, 8'h01, MPM_EX_ADDR);
    ex(MPM_FC_WRITE1, MPM_PARAM_HI + 16'h0001, 8'h01, MPM_EX_ADDR);
    ex(MPM_FC_READ, MPM_MON_HI + 16'h0001, 8'h00, MPM_EX_ADDR);
    ex(8'h05, MPM_ADDR_CTRL_MODE, 8'h00, MPM_EX_FUNC);
    ex(MPM_FC_WRITEN, MPM_ADDR_CTRL_MODE, 8'h00, MPM_EX_DATA);
    chk(control_mode, 16'd1000);
    req(MPM_FC_WRITEN, MPM_ADDR_CTRL_MODE, 8'h02, 32'h0002_0003);
    chk({control_mode, rsp_data[15:0]}, {16'h0003, 16'h0002});
    $display("t_map done");
  endtask
  // Commit on, slow store; host turns it off again afterwards
  task automatic t_persist();
    req(MPM_FC_WRITE1, MPM_ADDR_PERSIST, 8'h01, 32'h1);
    chk({persist_en, 16'(n_commits)}, {1'b1, 16'h0000});
    lat = 5;
    req(MPM_FC_WRITE1, MPM_ADDR_CTRL_MODE, 8'h01, 32'h2);
    chk({nvm_req, nvm_wide, req_ready}, 3'b100);
    req(MPM_FC_READ, MPM_ADDR_CTRL_MODE, 8'h01, 32'h0);
    chk(rsp_data, 32'h2);
    chk({seen_addr, seen_data}, {MPM_ADDR_CTRL_MODE, 32'h2});
    // Wide commit; low-first order still set, so low half lands at the lower address
    req(MPM_FC_WRITEN, MPM_ADDR_CTRL_MODE, 8'h02, 32'h0004_0003);
    chk({nvm_req, nvm_wide, control_mode}, {2'b11, 16'h0003});
    req(MPM_FC_WRITE1, MPM_ADDR_PERSIST, 8'h01, 32'h0);
    chk(persist_en, 1'b0);
    chk(seen_data, 32'h0004_0003);
    $display("t_persist done");
  endtask
  // Memory failure sticks and blocks committed writes
  task automatic t_fault();
    @(negedge clk) fail_cmd = 1'b1;
    repeat (2) @(negedge clk);
    fail_cmd = 1'b0;
    repeat (20) @(negedge clk);
    chk(drive_fault, 1'b1);
    req(MPM_FC_WRITE1, MPM_ADDR_PERSIST, 8'h01, 32'h1);
    ex(MPM_FC_WRITE1, MPM_ADDR_CTRL_MODE, 8'h01, MPM_EX_DEV);
    chk({drive_fault, control_mode}, {1'b1, 16'h0003});
    $display("t_fault done");
  endtask

  // --------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_count = 8'h00;
    req_data = 32'h0;
    servo_state = 16'h00a5;
    turn_position = 32'h1234_5678;
    fail_cmd = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_baud();
    t_fmt();
    t_order();
    t_map();
    t_persist();
    t_fault();
    stop_test();
  end
  // About 110 cycles expected; generous margin before cutting off
  initial begin
    #(40 * 20000);
    n_errors++;
    stop_test();
  end
endmodule // testbench
